// ==== debug_pkg.sv ====
// debug_pkg: shared constants for the breakpoint and single-step logic
// assumes: both ends compiled after this package
package debug_pkg;
    localparam int addr_width = 16;
    localparam int page_width = 4;
    localparam int offset_width = 12;
    localparam int page_msb = 15;
    localparam int page_lsb = 12;
    // cycles counted before the trace-done pulse
    localparam logic [4:0] trace_done_count = 5'h0F;
    localparam logic [4:0] trace_count_zero = 5'h00;
    // wishbone register offsets of the monitor end (byte addresses); the monitor has no reg_bp_addr register, so it reads zero
    localparam logic [3:0] reg_control = 4'h0;
    localparam logic [3:0] reg_status = 4'h4;
    localparam logic [3:0] reg_mask = 4'h8;
    localparam logic [3:0] reg_bp_addr = 4'hC;
    // control register fields
    localparam int ctl_page_lsb = 4;
    localparam int ctl_wr0 = 0;
    localparam int ctl_wr1 = 1;
    localparam int ctl_wronly = 2;
    localparam int ctl_trace = 3;
    localparam logic [7:0] ctl_reset_value = 8'h08;
    // status bits
    localparam int st_trace_done = 0;
    localparam int st_nmi = 1;
    localparam int st_width = 2;
endpackage : debug_pkg

// ==== debug_link_if.sv ====
// debug_link_if: parallel adapter lines between monitor end and debug logic
// assumes: one clock, testbench instantiates and joins both ends
`timescale 1ns/1ps
`default_nettype none
interface debug_link_if;
    import debug_pkg::*;
    logic [page_width-1:0] page_select;
    logic bp_write_line_0;
    logic bp_write_line_1;
    logic write_only_qualifier;
    logic trace_start_line;
    logic trace_done_input;
    logic nmi_seen;
    modport device (
        input page_select, bp_write_line_0, bp_write_line_1,
        input write_only_qualifier, trace_start_line,
        output trace_done_input, nmi_seen
    );
    modport monitor (
        output page_select, bp_write_line_0, bp_write_line_1,
        output write_only_qualifier, trace_start_line,
        input trace_done_input, nmi_seen
    );
endinterface : debug_link_if
`default_nettype wire

// ==== breakpoint_trace.sv ====
// breakpoint_trace: breakpoint memory, page compare and single-step counter
// assumes: host bus signals synchronous to sys_clk, one bus cycle per clock;
// adapter lines come from the monitor end on the same clock
//
// Summary of operation
// - 4K x 1 breakpoint bit beside memory
// - monitor marks breakpoint by writing zero
// - access to zero bit raises NMI
// - any number of marks per page
// - page lines compared with address 15:12
// - two write lines store marks
// - qualifier limits breakpoints to write cycles
// - stepping only from inside NMI handler
// - trace start dropped just before return
// - counter counts host machine cycles
// - fifteenth cycle pulses trace done
// - NMI one cycle after trace done
// - trace NMI ends after one cycle
// - handler raises trace start, resetting counter
`timescale 1ns/1ps
`default_nettype none
module breakpoint_trace
    import debug_pkg::*;
#(
    parameter int depth = 4096
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host processor bus, one machine cycle per clock
    input wire logic [addr_width-1:0] bus_addr,
    input wire logic bus_valid,
    input wire logic bus_write,
    // monitor side
    debug_link_if.device link,
    // interrupt request to the host processor, active high
    output logic nmi_req
);
    // limits: the host bus is taken as synchronous to sys_clk,
    // one machine cycle per clock; a stretched bus cycle would
    // lengthen the step and needs a cycle strobe in front

    // geometry checks: the page split must cover the address
    if (depth != (1 << offset_width)) begin : g_depth_check
        $error("depth must match the page size");
    end

    if (page_msb - page_lsb + 1 != page_width) begin : g_page_check
        $error("page field width must match the page lines");
    end

    if (page_lsb != offset_width) begin : g_split_check
        $error("page field must sit just above the offset");
    end

    if (page_msb != addr_width - 1) begin : g_top_check
        $error("page field must end at the top address bit");
    end

    // a zero length would leave no cycle for the return to run
    if (trace_done_count == trace_count_zero) begin : g_count_check
        $error("trace length must be at least one cycle");
    end

    // last counter value before the done pulse is launched
    localparam logic [4:0] last_step = trace_done_count - 5'h01;

    // offset of an address inside the selected page
    function automatic logic [offset_width-1:0] page_offset(
        input logic [addr_width-1:0] addr
    );
        return addr[offset_width-1:0];
    endfunction : page_offset

    // high address bits that name the page; compared against
    // the page lines on every access
    function automatic logic [page_width-1:0] page_field(
        input logic [addr_width-1:0] addr
    );
        return addr[page_msb:page_lsb];
    endfunction : page_field

    // with the qualifier set only write cycles may break
    function automatic logic cycle_qualifies(
        input logic write_only,
        input logic is_write
    );
        return !write_only || is_write;
    endfunction : cycle_qualifies

    // one counter step; it rests at the done count so the
    // pulse cannot repeat until the start line is raised again
    function automatic logic [4:0] count_step(
        input logic [4:0] count
    );
        if (count == trace_done_count) begin
            return count;
        end
        return count + 5'h01;
    endfunction : count_step

    // breakpoint memory, one mark bit per location of the page
    logic bp_mem [0:depth-1];

    // page compare and mark lookup of the current access
    logic page_hit;
    logic [offset_width-1:0] mark_addr;
    logic mark_bit;
    logic mark_write;
    logic bp_fire;

    // single-step counter and its done pulse
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic done_q;
    logic done_d;

    // interrupt request towards the host
    logic nmi_q;
    logic nmi_d;

    // one offset serves both the lookup and the mark write
    assign mark_addr = page_offset(bus_addr);

    // compare page lines with high address bits; a miss keeps
    // the memory idle, so other pages never break
    assign page_hit = bus_valid &&
        (page_field(bus_addr) == link.page_select);

    // stored bit as it stands before this edge's write;
    // an unfilled location reads unknown, so fill the page first
    assign mark_bit = bp_mem[mark_addr];

    // line 0 is the strobe, line 1 the value stored
    assign mark_write = page_hit && link.bp_write_line_0;

    // a zero bit marks a breakpoint; qualifier masks read cycles
    assign bp_fire = page_hit && !mark_bit &&
        cycle_qualifies(link.write_only_qualifier, bus_write);

    // mark memory, written on any page access while the strobe
    // is up; no reset: the monitor must fill every location
    // before it arms a page
    always_ff @(posedge sys_clk) begin
        if (mark_write) begin
            bp_mem[mark_addr] <= link.bp_write_line_1;
        end
    end

    // next count; the start line overrides the step
    always_comb begin
        count_d = count_step(count_q);
        if (link.trace_start_line) begin
            count_d = trace_count_zero;
        end
    end

    // machine cycle counter, one host cycle per clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_q <= trace_count_zero;
        end else begin
            count_q <= count_d;
        end
    end

    // done is decoded one step early so that it leaves a flip-flop
    // at the edge where the counter reaches its last count
    always_comb begin
        done_d = 1'b0;
        if (!link.trace_start_line && count_q == last_step) begin
            done_d = 1'b1;
        end
    end

    // trace done pulse towards the adapter, one cycle wide
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // request follows done by one cycle; a breakpoint hit asks
    // in the cycle after the access that hit
    always_comb begin
        nmi_d = done_q | bp_fire;
    end

    // a one-cycle pulse, not a level: it is gone before the first
    // user cycle ends, so exactly one instruction runs per step
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= nmi_d;
        end
    end

    // outputs straight from their flip-flops
    assign nmi_req = nmi_q;
    assign link.trace_done_input = done_q;
    assign link.nmi_seen = nmi_q;
endmodule : breakpoint_trace
`default_nettype wire

// ==== debug_monitor_port.sv ====
// debug_monitor_port: wishbone registers that drive the adapter lines
// assumes: classic wishbone master on sys_clk, debug logic on same clock
`timescale 1ns/1ps
`default_nettype none
module debug_monitor_port
    import debug_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt to software
    output logic irq,
    // adapter lines
    debug_link_if.monitor link
);
    logic [7:0] ctl_q;
    logic [st_width-1:0] status_q;
    logic [st_width-1:0] mask_q;
    logic [31:0] dat_q;
    logic ack_q;
    logic irq_q;
    logic req;
    logic rd_status;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign rd_status = req && !wb_we_i && (wb_adr_i == reg_status);

    // register writes; one-cycle ack, dropped the next cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctl_q <= ctl_reset_value; // start line high: counter idle
            mask_q <= '0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
            if (req && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == reg_control) begin
                    ctl_q <= wb_dat_i[7:0];
                end else if (wb_adr_i == reg_mask) begin
                    mask_q <= wb_dat_i[st_width-1:0];
                end
            end
        end
    end

    // sticky events; a new event wins over the read clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (rd_status ? '0 : status_q) |
                {link.nmi_seen, link.trace_done_input};
        end
    end

    // read data, unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dat_q <= '0;
        end else if (wb_adr_i == reg_control) begin
            dat_q <= {24'h000000, ctl_q};
        end else if (wb_adr_i == reg_status) begin
            dat_q <= {{(32 - st_width){1'b0}}, status_q};
        end else if (wb_adr_i == reg_mask) begin
            dat_q <= {{(32 - st_width){1'b0}}, mask_q};
        end else begin
            dat_q <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) irq_q <= 1'b0;
        else irq_q <= |(status_q & mask_q);
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign irq = irq_q;
    assign link.page_select = ctl_q[ctl_page_lsb +: page_width];
    assign link.bp_write_line_0 = ctl_q[ctl_wr0];
    assign link.bp_write_line_1 = ctl_q[ctl_wr1];
    assign link.write_only_qualifier = ctl_q[ctl_wronly];
    assign link.trace_start_line = ctl_q[ctl_trace];
endmodule : debug_monitor_port
`default_nettype wire

// ==== debug_link_assertions.sv ====
// debug_link_assertions: timing checks on the adapter lines
// assumes: instantiated beside the link, one clock domain
`timescale 1ns/1ps
`default_nettype none
module debug_link_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // adapter lines
    input wire logic [3:0] page_select,
    input wire logic bp_write_line_0,
    input wire logic bp_write_line_1,
    input wire logic write_only_qualifier,
    input wire logic trace_start_line,
    input wire logic trace_done_input,
    input wire logic nmi_seen
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [4:0] low_q;
    // low cycles since trace start; saturates so it never wraps
    always_ff @(posedge sys_clk) begin
        if (reset || trace_start_line) low_q <= 5'h00;
        else if (low_q != 5'h1F) low_q <= low_q + 5'h01;
    end
    start_high_a: assert property ($fell(reset) |-> trace_start_line)
        else $error("trace start low after reset");
    held_clear_a: assert property (trace_start_line [*2] |-> !trace_done_input)
        else $error("trace done while held");
    step_len_a: assert property ($fell(trace_start_line) |-> ##15 trace_done_input)
        else $error("trace done missing");
    done_count_a: assert property (trace_done_input |-> low_q == 5'h0F)
        else $error("trace done at wrong count");
    done_once_a: assert property (trace_done_input |=> !trace_done_input [*8])
        else $error("trace done repeated");
    nmi_after_a: assert property (trace_done_input |=> nmi_seen)
        else $error("no nmi after trace done");
    nmi_end_a: assert property (trace_done_input ##1 nmi_seen |=> !nmi_seen)
        else $error("trace nmi too long");
    restart_a: assert property ($rose(trace_start_line) |-> !trace_done_input ##1 !trace_done_input)
        else $error("trace done after restart");
endmodule : debug_link_assertions
`default_nettype wire

// ==== test_breakpoint_and_single_step.sv ====
// test_breakpoint_and_single_step: both ends joined, wishbone driven
// assumes: package, link, both ends and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_breakpoint_and_single_step;
    import debug_pkg::*;
    logic sys_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic bus_valid = 0, bus_write = 0, wb_ack_o, irq, nmi_req;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [15:0] bus_addr = 16'h0000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q;
    int n_fail = 0, checks = 0, i;
    `define chk(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
        $display("mismatch %s exp %0h got %0h", nm, e, g); end end
    debug_link_if link ();
    breakpoint_trace i_breakpoint_trace (.sys_clk, .reset, .bus_addr,
        .bus_valid, .bus_write, .link(link.device), .nmi_req);
    debug_monitor_port i_debug_monitor_port (.sys_clk, .reset, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .irq, .link(link.monitor));
    debug_link_assertions i_debug_link_assertions (.sys_clk, .reset,
        .page_select(link.page_select), .bp_write_line_0(link.bp_write_line_0),
        .bp_write_line_1(link.bp_write_line_1),
        .write_only_qualifier(link.write_only_qualifier),
        .trace_start_line(link.trace_start_line),
        .trace_done_input(link.trace_done_input), .nmi_seen(link.nmi_seen));
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    task automatic finish_test;
        $display("fail %0d checks %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // classic wishbone cycle; ack sampled at the edge, no latency assumed
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge sys_clk);
        if (k == 20) begin n_fail++; finish_test(); end
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    // one host machine cycle; nmi checked in the following cycle
    task automatic acc(input logic [15:0] a, input logic w, c, e);
        @(posedge sys_clk);
        {bus_addr, bus_valid, bus_write} <= {a, 1'b1, w};
        @(posedge sys_clk);
        bus_valid <= 0;
        #1 if (c) `chk("nmi_req", e, nmi_req)
    endtask : acc
    // main sequence: reset, marks, hits, interrupt, two trace steps
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 0;
        wb(0, reg_control, 0); `chk("control", ctl_reset_value, rd_q[7:0])
        wb(0, 4'hC, 0); `chk("unmapped", 32'h0, rd_q)
        wb(1, reg_mask, 0);
        // memory is not reset, so the whole page is set to one first
        wb(1, reg_control, 32'h3B);
        for (i = 0; i < 4096; i++) acc(16'h3000 + 16'(i), 1, 0, 0);
        wb(1, reg_control, 32'h39);
        acc(16'h3123, 0, 0, 0); acc(16'h3FFF, 0, 0, 0);
        wb(1, reg_control, 32'h38);
        wb(0, reg_status, 0);
        acc(16'h3123, 0, 1, 1); acc(16'h3124, 0, 1, 0);
        acc(16'h4123, 0, 1, 0); acc(16'h3FFF, 1, 1, 1);
        wb(1, reg_control, 32'h3C);
        acc(16'h3123, 0, 1, 0); acc(16'h3123, 1, 1, 1);
        $display("breakpoint tests done");
        `chk("irq masked", 1'b0, irq)
        wb(1, reg_mask, 32'h3); repeat (2) @(posedge sys_clk);
        #1 `chk("irq", 1'b1, irq)
        wb(0, reg_status, 0); `chk("status nmi", 1'b1, rd_q[st_nmi])
        repeat (2) @(posedge sys_clk);
        #1 `chk("irq cleared", 1'b0, irq)
        $display("interrupt test done");
        // a second step only fires if raising the line cleared the count
        repeat (2) begin
            wb(1, reg_control, 32'h30);
            for (i = 0; i < 40 && link.trace_done_input !== 1'b1; i++)
                @(posedge sys_clk);
            if (i == 40) begin n_fail++; finish_test(); end
            `chk("trace length", int'(trace_done_count), i)
            #1 `chk("trace nmi", 1'b1, nmi_req)
            @(posedge sys_clk); #1 `chk("trace nmi end", 1'b0, nmi_req)
            wb(0, reg_status, 0);
            `chk("status done", 1'b1, rd_q[st_trace_done])
            wb(1, reg_control, 32'h38);
            repeat (20) @(posedge sys_clk);
        end
        $display("trace test done");
        finish_test();
    end
endmodule : test_breakpoint_and_single_step
`default_nettype wire
